// *** fbc_pkg.sv ***
package fbc_pkg;

    // ------------------------------------------------------------
    // widths and sizes
    // ------------------------------------------------------------
    localparam int SAMPLE_W   = 10;
    localparam int ADDR_W     = 10;
    localparam int MEM_DEPTH  = 1024;
    localparam int TIME_W     = 10;
    localparam int QUARTER_W  = 2;
    localparam int Q_W        = SAMPLE_W + QUARTER_W;
    localparam int FRAC_W     = 15;
    localparam int ACC_W      = SAMPLE_W + FRAC_W;
    localparam int SHIFT_W    = 4;
    localparam int FIFO_DEPTH = 16;

    // ------------------------------------------------------------
    // values
    // ------------------------------------------------------------
    localparam logic [TIME_W-1:0]   WINDOW_MAX   = 10'h3F0;
    localparam logic [TIME_W-1:0]   TIME_ONE     = 10'h001;
    localparam logic [TIME_W-1:0]   TIME_ZERO    = 10'h000;
    localparam logic [SAMPLE_W-1:0] SAMPLE_ZERO  = 10'h000;
    localparam logic [Q_W-1:0]      Q_ZERO       = 12'h000;
    localparam logic [ACC_W-1:0]    ACC_ZERO     = 25'h0000000;
    localparam logic [FRAC_W-1:0]   FRAC_ZERO    = 15'h0000;
    localparam logic [QUARTER_W-1:0] QUARTER_ZERO = 2'h0;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FBC_SUB_NONE,
        FBC_SUB_FIXED,
        FBC_SUB_TABLE
    } fbc_sub_e;

    typedef enum logic {
        FBC_WIN_IDLE,
        FBC_WIN_OPEN
    } fbc_win_e;

    typedef struct packed {
        fbc_sub_e              sub_sel;
        logic                  selfcal_en;
        logic                  conv_en;
        logic                  test_en;
        logic                  invert_en;
        logic [SHIFT_W-1:0]    avg_shift;
        logic [SAMPLE_W-1:0]   fixed_ped;
        logic [TIME_W-1:0]     window_len;
    } fbc_cfg_s;

    typedef struct packed {
        logic                  wr;
        logic                  rd;
        logic [ADDR_W-1:0]     addr;
        logic [SAMPLE_W-1:0]   wdata;
    } fbc_mem_req_s;

endpackage

// *** fbc_fifo.sv ***
`timescale 1ns/1ps
module fbc_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 16
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_b,
    input  wire logic             s_valid,
    output logic                  s_ready,
    input  wire logic [WIDTH-1:0] s_data,
    output logic                  m_valid,
    input  wire logic             m_ready,
    output logic      [WIDTH-1:0] m_data
);

    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = PTR_W + 1;
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

    logic [WIDTH-1:0] store_reg [DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [CNT_W-1:0] count_reg;
    logic             push;
    logic             pop;

    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
        ptr_inc = (p == PTR_LAST) ? '0 : p + 1'b1;
    endfunction

    assign s_ready = (count_reg != CNT_FULL);
    assign m_valid = (count_reg != '0);
    assign push    = s_valid && s_ready;
    assign pop     = m_valid && m_ready;
    assign m_data  = store_reg[rd_ptr_reg];

    always_ff @(posedge ref_clk)
    begin
        if (push)
        begin
            store_reg[wr_ptr_reg] <= s_data;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_reg <= ptr_inc(wr_ptr_reg);
            end
            if (pop)
            begin
                rd_ptr_reg <= ptr_inc(rd_ptr_reg);
            end
            if (push && !pop)
            begin
                count_reg <= count_reg + 1'b1;
            end
            else if (pop && !push)
            begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

endmodule // fbc_fifo

// *** fbc_first_baseline_stage.sv ***
`timescale 1ns/1ps
module fbc_first_baseline_stage #(
    parameter int                          FIFO_DEPTH = fbc_pkg::FIFO_DEPTH,
    parameter logic [fbc_pkg::TIME_W-1:0]  WINDOW_MAX = fbc_pkg::WINDOW_MAX
) (
    input  wire logic                            ref_clk,
    input  wire logic                            rst_b,
    input  wire logic                            in_valid,
    output logic                                 in_ready,
    input  wire logic [fbc_pkg::SAMPLE_W-1:0]    in_sample,
    input  wire logic                            trigger,
    input  wire fbc_pkg::fbc_cfg_s               cfg,
    input  wire fbc_pkg::fbc_mem_req_s           mem_req,
    output logic      [fbc_pkg::SAMPLE_W-1:0]    mem_rdata,
    output logic                                 mem_rack,
    output logic                                 processing_window,
    output logic      [fbc_pkg::SAMPLE_W-1:0]    baseline_held,
    output logic                                 out_valid,
    input  wire logic                            out_ready,
    output logic      [fbc_pkg::SAMPLE_W-1:0]    out_data
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [fbc_pkg::SAMPLE_W-1:0] ped_mem_reg [fbc_pkg::MEM_DEPTH];
    logic [fbc_pkg::SAMPLE_W-1:0] mem_rdata_reg;
    logic                         mem_rack_reg;

    fbc_pkg::fbc_win_e            win_state_reg;
    logic [fbc_pkg::TIME_W-1:0]   time_cnt_reg;
    logic [fbc_pkg::TIME_W-1:0]   win_last;

    logic [fbc_pkg::ACC_W-1:0]    acc_reg;
    logic [fbc_pkg::ACC_W-1:0]    acc_next;
    logic [fbc_pkg::Q_W-1:0]      held_reg;
    logic [fbc_pkg::Q_W-1:0]      acc_quarter;
    logic [fbc_pkg::Q_W-1:0]      baseline_q;
    logic                         avg_en;
    logic                         held_en;

    logic                         accept;
    logic                         mode_fixed;
    logic [fbc_pkg::SAMPLE_W-1:0] din;
    logic [fbc_pkg::SAMPLE_W-1:0] table_word;
    logic [fbc_pkg::Q_W-1:0]      table_q;
    logic [fbc_pkg::SAMPLE_W-1:0] result;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // works in quarter counts so the table's finer resolution survives
    function automatic logic [fbc_pkg::Q_W-1:0] sub_clamp(
        input logic [fbc_pkg::Q_W-1:0] a,
        input logic [fbc_pkg::Q_W-1:0] b
    );
        sub_clamp = (a > b) ? a - b : fbc_pkg::Q_ZERO;
    endfunction

    function automatic logic [fbc_pkg::Q_W-1:0] to_quarter(
        input logic [fbc_pkg::SAMPLE_W-1:0] v
    );
        to_quarter = {v, fbc_pkg::QUARTER_ZERO};
    endfunction

    function automatic logic [fbc_pkg::SAMPLE_W-1:0] from_quarter(
        input logic [fbc_pkg::Q_W-1:0] q
    );
        from_quarter = q[fbc_pkg::Q_W-1:fbc_pkg::QUARTER_W];
    endfunction

    // fixed pedestal is kept in whole counts
    function automatic logic [fbc_pkg::Q_W-1:0] minus_fixed(
        input logic [fbc_pkg::Q_W-1:0]      v,
        input logic [fbc_pkg::SAMPLE_W-1:0] ped
    );
        minus_fixed = sub_clamp(v, to_quarter(ped));
    endfunction

    // ------------------------------------------------------------
    // pedestal memory and its access ports
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        // contents are not cleared by reset
        if (mem_req.wr)
        begin
            ped_mem_reg[mem_req.addr] <= mem_req.wdata;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            mem_rdata_reg <= fbc_pkg::SAMPLE_ZERO;
            mem_rack_reg  <= 1'b0;
        end
        else
        begin
            // a write to the same word in this cycle returns the old word
            mem_rack_reg <= mem_req.rd;
            if (mem_req.rd)
            begin
                mem_rdata_reg <= ped_mem_reg[mem_req.addr];
            end
        end
    end

    assign mem_rdata = mem_rdata_reg;
    assign mem_rack  = mem_rack_reg;

    // ------------------------------------------------------------
    // processing window and time counter
    // ------------------------------------------------------------
    // a longer programmed length is cut to WINDOW_MAX
    assign win_last = ((cfg.window_len > WINDOW_MAX) || (cfg.window_len == fbc_pkg::TIME_ZERO))
                      ? WINDOW_MAX - fbc_pkg::TIME_ONE
                      : cfg.window_len - fbc_pkg::TIME_ONE;

    // a trigger during an open window is ignored; no retrigger
    // the sample taken in the trigger cycle is still outside the window
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            win_state_reg <= fbc_pkg::FBC_WIN_IDLE;
            time_cnt_reg  <= fbc_pkg::TIME_ZERO;
        end
        else
        begin
            case (win_state_reg)
                fbc_pkg::FBC_WIN_IDLE:
                begin
                    if (trigger)
                    begin
                        win_state_reg <= fbc_pkg::FBC_WIN_OPEN;
                        time_cnt_reg  <= fbc_pkg::TIME_ZERO;
                    end
                end
                fbc_pkg::FBC_WIN_OPEN:
                begin
                    if (accept)
                    begin
                        if (time_cnt_reg >= win_last)
                        begin
                            win_state_reg <= fbc_pkg::FBC_WIN_IDLE;
                            time_cnt_reg  <= fbc_pkg::TIME_ZERO;
                        end
                        else
                        begin
                            time_cnt_reg <= time_cnt_reg + fbc_pkg::TIME_ONE;
                        end
                    end
                end
                default:
                begin
                    win_state_reg <= fbc_pkg::FBC_WIN_IDLE;
                    time_cnt_reg  <= fbc_pkg::TIME_ZERO;
                end
            endcase
        end
    end

    assign processing_window = (win_state_reg == fbc_pkg::FBC_WIN_OPEN);

    // ------------------------------------------------------------
    // self-calibrated pedestal
    // ------------------------------------------------------------
    assign accept = in_valid && in_ready;
    assign din    = cfg.invert_en ? ~in_sample : in_sample;

    // old - old/2^n + sample/2^n keeps FRAC_W fraction bits; n above FRAC_W
    // cannot occur because the shift field tops out at FRAC_W
    assign acc_next = acc_reg - (acc_reg >> cfg.avg_shift)
                    + ({din, fbc_pkg::FRAC_ZERO} >> cfg.avg_shift);

    assign acc_quarter = acc_reg[fbc_pkg::ACC_W-1:fbc_pkg::FRAC_W-fbc_pkg::QUARTER_W];

    // the trigger-cycle sample stays out of the frozen value
    assign avg_en  = accept && !processing_window && !trigger;
    assign held_en = trigger && !processing_window;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            acc_reg <= fbc_pkg::ACC_ZERO;
        end
        else if (avg_en)
        begin
            acc_reg <= acc_next;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            held_reg <= fbc_pkg::Q_ZERO;
        end
        else if (held_en)
        begin
            held_reg <= acc_quarter;
        end
    end

    // inside the window only the frozen value is used
    assign baseline_q    = processing_window ? held_reg : acc_quarter;
    assign baseline_held = from_quarter(held_reg);

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    // fixed selection also turns a test pattern into zeros
    assign mode_fixed = (cfg.sub_sel == fbc_pkg::FBC_SUB_FIXED);

    // ------------------------------------------------------------
    // correction datapath
    // ------------------------------------------------------------
    assign table_word = ped_mem_reg[time_cnt_reg];
    // table words are already quarter counts; outside a window word 0 is read
    assign table_q    = {fbc_pkg::QUARTER_ZERO, table_word};

    always_comb
    begin
        logic [fbc_pkg::Q_W-1:0]      y_q;
        logic [fbc_pkg::SAMPLE_W-1:0] y;
        y_q = fbc_pkg::Q_ZERO;
        y   = fbc_pkg::SAMPLE_ZERO;
        if (cfg.test_en)
        begin
            if (mode_fixed)
            begin
                y = fbc_pkg::SAMPLE_ZERO;
            end
            else
            begin
                // pattern words go out as stored
                y = table_word;
            end
        end
        else
        begin
            y_q = to_quarter(din);
            if (cfg.selfcal_en)
            begin
                y_q = sub_clamp(y_q, baseline_q);
            end
            if (cfg.conv_en)
            begin
                // memory is addressed by the sample, so the table subtraction is off
                y_q = to_quarter(ped_mem_reg[from_quarter(y_q)]);
                if (mode_fixed)
                begin
                    y_q = minus_fixed(y_q, cfg.fixed_ped);
                end
            end
            else
            begin
                // one select field keeps fixed and table exclusive
                case (cfg.sub_sel)
                    fbc_pkg::FBC_SUB_FIXED:
                    begin
                        y_q = minus_fixed(y_q, cfg.fixed_ped);
                    end
                    fbc_pkg::FBC_SUB_TABLE:
                    begin
                        y_q = sub_clamp(y_q, table_q);
                    end
                    default:
                    begin
                        y_q = y_q;
                    end
                endcase
            end
            // quarter bits are dropped, the output is whole counts
            y = from_quarter(y_q);
        end
        result = y;
    end

    // ------------------------------------------------------------
    // output buffer
    // ------------------------------------------------------------
    // a full buffer lowers in_ready and takes no sample, which
    // also pauses averaging and the time counter so they stay aligned
    fbc_fifo #(
        .WIDTH (fbc_pkg::SAMPLE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_out_fifo (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .s_valid (in_valid),
        .s_ready (in_ready),
        .s_data  (result),
        .m_valid (out_valid),
        .m_ready (out_ready),
        .m_data  (out_data)
    );

endmodule // fbc_first_baseline_stage

// *** fbc_first_baseline_stage_sva.sv ***
`timescale 1ns/1ps
module fbc_first_baseline_stage_sva #(
    parameter int                         FIFO_DEPTH = 16,
    parameter logic [fbc_pkg::TIME_W-1:0] WINDOW_MAX = 10'h3F0
) (
    input wire logic                         ref_clk,
    input wire logic                         rst_b,
    input wire logic                         in_valid,
    input wire logic                         in_ready,
    input wire logic [fbc_pkg::SAMPLE_W-1:0] in_sample,
    input wire logic                         trigger,
    input wire fbc_pkg::fbc_cfg_s            cfg,
    input wire fbc_pkg::fbc_mem_req_s        mem_req,
    input wire logic [fbc_pkg::SAMPLE_W-1:0] mem_rdata,
    input wire logic                         mem_rack,
    input wire logic                         processing_window,
    input wire logic [fbc_pkg::SAMPLE_W-1:0] baseline_held,
    input wire logic                         out_valid,
    input wire logic                         out_ready,
    input wire logic [fbc_pkg::SAMPLE_W-1:0] out_data
);
    logic [fbc_pkg::TIME_W:0] win_cnt;
    logic                     fixed_only;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    assign fixed_only = cfg.sub_sel == fbc_pkg::FBC_SUB_FIXED && !cfg.selfcal_en
        && !cfg.conv_en && !cfg.test_en && !cfg.invert_en;

    // --------------------------------
    // accepts seen inside the window
    // --------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b || !processing_window)
            win_cnt <= '0;
        else if (in_valid && in_ready)
            win_cnt <= win_cnt + 1'h1;
    end

    // --------------------------------
    // properties
    // --------------------------------
    // fifo empty, so the next word out belongs to this sample
    sequence s_take_empty;
        in_valid && in_ready && !out_valid;
    endsequence

    sequence s_win_two;
        processing_window ##1 processing_window;
    endsequence

    a_take_to_out: assert property (in_valid && in_ready |=> out_valid)
        else $error("accepted sample missing at output");
    a_fixed_clamp: assert property ((s_take_empty ##0 fixed_only) |=>
        out_data == ($past(in_sample) > $past(cfg.fixed_ped) ?
        $past(in_sample) - $past(cfg.fixed_ped) : 10'h000))
        else $error("fixed subtraction result wrong");
    a_test_zero: assert property ((s_take_empty ##0
        (cfg.test_en && cfg.sub_sel == fbc_pkg::FBC_SUB_FIXED)) |=> out_data == 10'h000)
        else $error("test pattern with constant not zero");
    a_rack_pulse: assert property (mem_req.rd |=> mem_rack)
        else $error("read not acknowledged");
    a_rack_only: assert property (!mem_req.rd |=> !mem_rack)
        else $error("acknowledge without read");
    a_rdata_hold: assert property (!mem_req.rd |=> $stable(mem_rdata))
        else $error("read data moved without read");
    a_window_open: assert property (trigger && !processing_window |=> processing_window)
        else $error("trigger did not open window");
    a_held_frozen: assert property (s_win_two |-> $stable(baseline_held))
        else $error("held pedestal moved inside window");
    a_window_bound: assert property (processing_window |-> win_cnt < WINDOW_MAX)
        else $error("window longer than maximum");
endmodule // fbc_first_baseline_stage_sva

bind fbc_first_baseline_stage fbc_first_baseline_stage_sva #(
    .FIFO_DEPTH(FIFO_DEPTH),
    .WINDOW_MAX(WINDOW_MAX)
) u_sva (
    .ref_clk(ref_clk), .rst_b(rst_b), .in_valid(in_valid), .in_ready(in_ready),
    .in_sample(in_sample), .trigger(trigger), .cfg(cfg), .mem_req(mem_req),
    .mem_rdata(mem_rdata), .mem_rack(mem_rack), .processing_window(processing_window),
    .baseline_held(baseline_held), .out_valid(out_valid), .out_ready(out_ready),
    .out_data(out_data)
);

// *** fbc_sink_model.sv ***
`timescale 1ns/1ps
module fbc_sink_model (
    input  wire logic ref_clk,
    input  wire logic rst_b,
    input  wire logic stall,
    output logic      out_ready
);
    // registered, so back-pressure lags the request by one edge like a real stage
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            out_ready <= 1'h0;
        else
            out_ready <= !stall;
    end
endmodule // fbc_sink_model

// *** fbc_first_baseline_stage_bench.sv ***
`timescale 1ns/1ps
module fbc_first_baseline_stage_bench;
    logic                         ref_clk;
    logic                         rst_b;
    logic                         in_valid;
    logic                         in_ready;
    logic [fbc_pkg::SAMPLE_W-1:0] in_sample;
    logic                         trigger;
    fbc_pkg::fbc_cfg_s            cfg;
    fbc_pkg::fbc_mem_req_s        mem_req;
    logic [fbc_pkg::SAMPLE_W-1:0] mem_rdata;
    logic                         mem_rack;
    logic                         processing_window;
    logic [fbc_pkg::SAMPLE_W-1:0] baseline_held;
    logic                         out_valid;
    logic                         out_ready;
    logic [fbc_pkg::SAMPLE_W-1:0] out_data;
    logic                         stall;
    logic [fbc_pkg::SAMPLE_W-1:0] exp_q[$];
    int                           errors;
    int                           samples_checked;

    fbc_first_baseline_stage #(
        .FIFO_DEPTH(16),
        .WINDOW_MAX(10'h008)
    ) dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .in_valid(in_valid), .in_ready(in_ready),
        .in_sample(in_sample), .trigger(trigger), .cfg(cfg), .mem_req(mem_req),
        .mem_rdata(mem_rdata), .mem_rack(mem_rack), .processing_window(processing_window),
        .baseline_held(baseline_held), .out_valid(out_valid), .out_ready(out_ready),
        .out_data(out_data)
    );

    fbc_sink_model u_sink (
        .ref_clk(ref_clk), .rst_b(rst_b), .stall(stall), .out_ready(out_ready)
    );

    initial
    begin
        ref_clk = 1'h0;
        forever #20 ref_clk = ~ref_clk;
    end

    // --------------------------------
    // access tasks, all start and end at a falling edge
    // --------------------------------
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize;
        $display("compared %0d bad %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // valid stays up afterwards so streams run back to back
    task automatic send(input logic [9:0] s, input logic [9:0] e);
        exp_q.push_back(e);
        in_valid = 1'h1;
        in_sample = s;
        while (in_ready !== 1'h1)
            @(negedge ref_clk);
        @(negedge ref_clk);
    endtask

    task automatic idle;
        in_valid = 1'h0;
        @(negedge ref_clk);
    endtask

    task automatic pulse_trig;
        trigger = 1'h1;
        @(negedge ref_clk);
        trigger = 1'h0;
    endtask

    task automatic mem_wr(input logic [9:0] a, input logic [9:0] d);
        mem_req = '{1'h1, 1'h0, a, d};
        @(negedge ref_clk);
        mem_req = '0;
        @(negedge ref_clk);
    endtask

    task automatic mem_rd(input logic [9:0] a, input logic [9:0] e);
        mem_req = '{1'h0, 1'h1, a, 10'h000};
        @(negedge ref_clk);
        mem_req = '0;
        chk(10'(mem_rack), 10'h001);
        chk(mem_rdata, e);
        @(negedge ref_clk);
        chk(10'(mem_rack), 10'h000);
    endtask

    task automatic set_cfg(input fbc_pkg::fbc_sub_e sub, input int sc, input int cv,
                           input int ts, input int inv, input logic [3:0] n,
                           input logic [9:0] ped, input logic [9:0] len);
        cfg = '{sub, 1'(sc), 1'(cv), 1'(ts), 1'(inv), n, ped, len};
    endtask

    task automatic drain(input string name);
        // the buffer must be empty too, so the next test starts on an idle output
        for (int i = 0; i < 200 && (exp_q.size() != 0 || out_valid !== 1'h0); i++)
            @(negedge ref_clk);
        chk(10'(exp_q.size()), 10'h000);
        $display("test %s done", name);
    endtask

    // --------------------------------
    // output scoreboard and watchdog
    // --------------------------------
    // looked at half a cycle before the popping edge, when it has settled
    always @(negedge ref_clk)
    begin
        if (rst_b === 1'h1 && out_valid === 1'h1 && out_ready === 1'h1)
        begin
            if (exp_q.size() != 0)
                chk(out_data, exp_q.pop_front());
            else
            begin
                errors++;
                $display("BAD %0t unexpected output word %h", $time, out_data);
            end
        end
    end

    initial
    begin
        repeat (5000) @(posedge ref_clk);
        errors++;
        summarize();
    end

    // --------------------------------
    // tests
    // --------------------------------
    initial
    begin
        rst_b = 1'h0;
        in_valid = 1'h0;
        in_sample = 10'h000;
        trigger = 1'h0;
        cfg = '0;
        mem_req = '0;
        stall = 1'h0;
        errors = 0;
        samples_checked = 0;
        repeat (2) @(negedge ref_clk);
        chk(10'({in_ready, out_valid, processing_window, mem_rack}), 10'h008);
        chk(baseline_held, 10'h000);
        rst_b = 1'h1;
        for (int k = 0; k < 8; k++)
            mem_wr(10'(k), 10'(4 * k + 2));
        mem_wr(10'h064, 10'h155);
        mem_wr(10'h3FF, 10'h3FF);
        mem_rd(10'h003, 10'h00E);
        mem_rd(10'h064, 10'h155);
        mem_rd(10'h3FF, 10'h3FF);
        drain("memory");
        set_cfg(fbc_pkg::FBC_SUB_FIXED, 0, 0, 0, 0, 4'h0, 10'h014, 10'h000);
        send(10'h064, 10'h050);
        send(10'h014, 10'h000);
        send(10'h005, 10'h000);
        set_cfg(fbc_pkg::FBC_SUB_FIXED, 0, 0, 0, 1, 4'h0, 10'h014, 10'h000);
        send(10'h3F0, 10'h000);
        send(10'h300, 10'h0EB);
        idle();
        drain("fixed");
        // zero length asks for the longest window
        set_cfg(fbc_pkg::FBC_SUB_TABLE, 0, 0, 0, 0, 4'h0, 10'h000, 10'h000);
        pulse_trig();
        chk(10'(processing_window), 10'h001);
        for (int k = 0; k < 8; k++)
            send(10'h032, 10'(49 - k));
        idle();
        chk(10'(processing_window), 10'h000);
        drain("table");
        set_cfg(fbc_pkg::FBC_SUB_NONE, 0, 0, 0, 0, 4'h0, 10'h000, 10'h000);
        send(10'h01E, 10'h01E);
        set_cfg(fbc_pkg::FBC_SUB_NONE, 1, 0, 0, 0, 4'h0, 10'h000, 10'h000);
        send(10'h028, 10'h00A);
        send(10'h02D, 10'h005);
        idle();
        set_cfg(fbc_pkg::FBC_SUB_TABLE, 1, 0, 0, 0, 4'h0, 10'h000, 10'h002);
        pulse_trig();
        chk(baseline_held, 10'h02D);
        send(10'h032, 10'h004);
        send(10'h02C, 10'h000);
        idle();
        chk(10'(processing_window), 10'h000);
        set_cfg(fbc_pkg::FBC_SUB_NONE, 1, 0, 0, 0, 4'h1, 10'h000, 10'h000);
        send(10'h03D, 10'h010);
        send(10'h03C, 10'h007);
        idle();
        drain("selfcal");
        set_cfg(fbc_pkg::FBC_SUB_NONE, 0, 1, 0, 0, 4'h0, 10'h000, 10'h000);
        send(10'h064, 10'h155);
        set_cfg(fbc_pkg::FBC_SUB_FIXED, 0, 1, 0, 0, 4'h0, 10'h005, 10'h000);
        send(10'h064, 10'h150);
        set_cfg(fbc_pkg::FBC_SUB_FIXED, 1, 1, 0, 0, 4'h0, 10'h005, 10'h000);
        send(10'h0C8, 10'h150);
        idle();
        drain("convert");
        set_cfg(fbc_pkg::FBC_SUB_NONE, 0, 0, 1, 0, 4'h0, 10'h000, 10'h002);
        pulse_trig();
        send(10'h3FF, 10'h002);
        send(10'h3FF, 10'h006);
        idle();
        drain("pattern");
        set_cfg(fbc_pkg::FBC_SUB_FIXED, 0, 0, 1, 0, 4'h0, 10'h005, 10'h000);
        send(10'h3FF, 10'h000);
        idle();
        drain("zeros");
        stall = 1'h1;
        set_cfg(fbc_pkg::FBC_SUB_NONE, 0, 0, 0, 0, 4'h0, 10'h000, 10'h000);
        for (int k = 0; k < 16; k++)
            send(10'(k + 1), 10'(k + 1));
        chk(10'(in_ready), 10'h000);
        idle();
        stall = 1'h0;
        drain("fifo");
        summarize();
    end
endmodule // fbc_first_baseline_stage_bench
